// ==== src/evp_core.sv ====
// Exception vector prioritizer: pending, masking, ranking and active nesting.
// Assumes core-side strobes are on clk_i; only the NMI pin is asynchronous.
`timescale 1ns/1ns
module evp_core #(
	parameter bit HAS_BUSDEV = 1'b1
) (
	// Clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	// Asynchronous non-maskable pin
	input  wire logic                             nmi_pin_i,
	// Core event strobes, with the monitor/halt qualifiers and fault handler enables
	input  wire logic                             mem_fault_i,
	input  wire logic                             bus_fault_precise_i,
	input  wire logic                             bus_fault_imprecise_i,
	input  wire logic                             usage_fault_i,
	input  wire logic                             svc_i,
	input  wire logic                             debug_mon_i,
	input  wire logic                             monitor_en_i,
	input  wire logic                             halting_i,
	input  wire logic                             pendable_service_request_set_i,
	input  wire logic                             pendable_service_request_clr_i,
	input  wire logic                             system_tick_exception_i,
	input  wire logic [evp_pkg::NUM_FLT-1:0]      fault_handler_en_i,
	// Peripheral lines and their control
	input  wire logic [evp_pkg::NUM_IRQ-1:0]      periph_irq_i,
	input  wire logic [evp_pkg::NUM_IRQ-1:0]      pending_set_register_i,
	input  wire logic [evp_pkg::NUM_IRQ-1:0]      pending_clr_i,
	input  wire logic [evp_pkg::NUM_IRQ-1:0]      enable_set_register_i,
	input  wire logic [evp_pkg::NUM_IRQ-1:0]      enable_clr_i,
	// Priority and vector table load
	input  wire logic                             prio_we_i,
	input  wire evp_pkg::evp_pos_t                prio_pos_i,
	input  wire evp_pkg::evp_pri_t                prio_val_i,
	input  wire logic                             vt_we_i,
	input  wire evp_pkg::evp_pos_t                vt_pos_i,
	input  wire logic [evp_pkg::VEC_W-1:0]        vt_data_i,
	// Core handshake
	input  wire logic                             exc_ack_i,
	input  wire logic                             exc_return_i,
	// Request to core
	output logic                                  exc_req_o,
	output evp_pkg::evp_pos_t                     exc_pos_o,
	output logic [evp_pkg::VEC_W-1:0]             handler_o,
	output logic [evp_pkg::VEC_W-1:0]             stack_init_o,
	// Status
	output evp_pkg::evp_lvl_t                     running_lvl_o,
	output logic [evp_pkg::NUM_POS-1:0]           active_o,
	output logic [evp_pkg::NUM_POS-1:0]           pending_o,
	output logic [evp_pkg::NUM_IRQ-1:0]           irq_enable_o
);
	localparam int N = evp_pkg::NUM_POS;

	// Table state
	logic [evp_pkg::VEC_W-1:0] vt_r   [N];
	logic [evp_pkg::VEC_W-1:0] vt_nxt [N];
	evp_pkg::evp_pri_t         pri_r  [N];
	evp_pkg::evp_pri_t         pri_nxt[N];
	// Control state
	logic [N-1:0]                  pend_r, pend_nxt;
	logic [N-1:0]                  act_r, act_nxt;
	logic [evp_pkg::NUM_IRQ-1:0]   en_r, en_nxt;
	logic                          nmi_s1_r, nmi_s2_r, nmi_s3_r;
	logic                          req_r, req_nxt;
	evp_pkg::evp_pos_t             pos_r, pos_nxt;
	logic [evp_pkg::VEC_W-1:0]     hdl_r, hdl_nxt, sp_r, sp_nxt;
	evp_pkg::evp_lvl_t             run_r, run_nxt;
	// Ranking
	evp_pkg::evp_lvl_t             lvl [N];
	logic [N-1:0]                  elig;
	logic                          win_v, act_v, take, nmi_edge;
	evp_pkg::evp_pos_t             win_pos, act_pos;
	evp_pkg::evp_lvl_t             win_lvl, act_lvl, cur_lvl;
	logic [evp_pkg::NUM_IRQ-1:0]   line_present;

	evp_arbiter u_pend_arb (
		.req_i   (elig),
		.lvl_i   (lvl),
		.valid_o (win_v),
		.pos_o   (win_pos),
		.lvl_o   (win_lvl)
	);

	// Second ranking over actives yields the running level
	evp_arbiter u_act_arb (
		.req_i   (act_r),
		.lvl_i   (lvl),
		.valid_o (act_v),
		.pos_o   (act_pos),
		.lvl_o   (act_lvl)
	);

	always_comb begin
		for (int i = 0; i < N; i++) begin
			lvl[i] = evp_pkg::evp_level(evp_pkg::POS_W'(i), pri_r[i]);
		end
		cur_lvl  = act_v ? act_lvl : evp_pkg::LVL_BASE;
		nmi_edge = nmi_s2_r && !nmi_s3_r;
		// Top line exists only on variants carrying the bus device
		line_present = {HAS_BUSDEV, {(evp_pkg::NUM_IRQ-1){1'b1}}};
		elig = pend_r & {en_r, evp_pkg::SYS_ALWAYS} & ~evp_pkg::RESERVED_MASK;
		take = win_v && (win_lvl < cur_lvl);
	end

	// Table group: software priority and vector slots
	always_comb begin
		vt_nxt  = vt_r;
		pri_nxt = pri_r;
		if (vt_we_i) begin
			vt_nxt[vt_pos_i] = vt_data_i;
		end
		// Fixed-level positions ignore writes through evp_level
		if (prio_we_i) begin
			pri_nxt[prio_pos_i] = prio_val_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < N; i++) begin
				vt_r[i]  <= evp_pkg::VEC_RST;
				pri_r[i] <= evp_pkg::PRI_RST;
			end
		end else begin
			vt_r  <= vt_nxt;
			pri_r <= pri_nxt;
		end
	end

	// Control group
	always_comb begin
		pend_nxt = pend_r;
		act_nxt  = act_r;
		en_nxt   = en_r;
		// Clears first so that a same-cycle set wins
		pend_nxt[N-1:evp_pkg::IRQ_BASE] = pend_r[N-1:evp_pkg::IRQ_BASE] & ~pending_clr_i;
		if (pendable_service_request_clr_i) begin
			pend_nxt[evp_pkg::POS_PENDABLE_SERVICE_REQUEST] = 1'b0;
		end
		if (exc_ack_i && req_r) begin
			pend_nxt[pos_r] = 1'b0;
			// Reset is never stacked: start code runs at base level
			if (pos_r != evp_pkg::POS_RESET) begin
				act_nxt[pos_r] = 1'b1;
			end
		end
		if (exc_return_i && act_v) begin
			act_nxt[act_pos] = 1'b0;
		end
		// Peripheral lines are level sensitive; pending may precede enable
		pend_nxt[N-1:evp_pkg::IRQ_BASE] = pend_nxt[N-1:evp_pkg::IRQ_BASE]
			| ((periph_irq_i | pending_set_register_i) & line_present);
		if (nmi_edge) begin
			pend_nxt[evp_pkg::POS_NMI] = 1'b1;
		end
		if (mem_fault_i) begin
			if (fault_handler_en_i[evp_pkg::FLT_MEM] && lvl[evp_pkg::POS_MEM] < cur_lvl)
				pend_nxt[evp_pkg::POS_MEM] = 1'b1;
			else
				pend_nxt[evp_pkg::POS_HARD] = 1'b1;
		end
		if (bus_fault_precise_i || bus_fault_imprecise_i) begin
			if (fault_handler_en_i[evp_pkg::FLT_BUS] && lvl[evp_pkg::POS_BUS] < cur_lvl)
				pend_nxt[evp_pkg::POS_BUS] = 1'b1;
			else
				pend_nxt[evp_pkg::POS_HARD] = 1'b1;
		end
		if (usage_fault_i) begin
			if (fault_handler_en_i[evp_pkg::FLT_USAGE] && lvl[evp_pkg::POS_USAGE] < cur_lvl)
				pend_nxt[evp_pkg::POS_USAGE] = 1'b1;
			else
				pend_nxt[evp_pkg::POS_HARD] = 1'b1;
		end
		if (svc_i) begin
			pend_nxt[evp_pkg::POS_SVC] = 1'b1;
		end
		if (debug_mon_i && monitor_en_i && !halting_i && lvl[evp_pkg::POS_DBGMON] < cur_lvl) begin
			pend_nxt[evp_pkg::POS_DBGMON] = 1'b1;
		end
		if (pendable_service_request_set_i) begin
			pend_nxt[evp_pkg::POS_PENDABLE_SERVICE_REQUEST] = 1'b1;
		end
		if (system_tick_exception_i) begin
			pend_nxt[evp_pkg::POS_TICK] = 1'b1;
		end
		pend_nxt = pend_nxt & ~evp_pkg::RESERVED_MASK;
		en_nxt = (en_r & ~enable_clr_i) | enable_set_register_i;
		// One idle cycle after an ack lets the stack settle before re-ranking
		req_nxt = take && !exc_ack_i;
		pos_nxt = take ? win_pos : pos_r;
		hdl_nxt = take ? vt_r[win_pos] : hdl_r;
		sp_nxt  = (take && win_pos == evp_pkg::POS_RESET) ? vt_r[evp_pkg::POS_STACK] : sp_r;
		run_nxt = cur_lvl;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_r   <= 36'h0_0000_0002;
			act_r    <= '0;
			en_r     <= '0;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_s3_r <= 1'b0;
			req_r    <= 1'b0;
			pos_r    <= evp_pkg::POS_STACK;
			hdl_r    <= evp_pkg::VEC_RST;
			sp_r     <= evp_pkg::VEC_RST;
			run_r    <= evp_pkg::LVL_BASE;
		end else begin
			pend_r   <= pend_nxt;
			act_r    <= act_nxt;
			en_r     <= en_nxt;
			nmi_s1_r <= nmi_pin_i;
			nmi_s2_r <= nmi_s1_r;
			nmi_s3_r <= nmi_s2_r;
			req_r    <= req_nxt;
			pos_r    <= pos_nxt;
			hdl_r    <= hdl_nxt;
			sp_r     <= sp_nxt;
			run_r    <= run_nxt;
		end
	end

	assign exc_req_o     = req_r;
	assign exc_pos_o     = pos_r;
	assign handler_o     = hdl_r;
	assign stack_init_o  = sp_r;
	assign running_lvl_o = run_r;
	assign active_o      = act_r;
	assign pending_o     = pend_r;
	assign irq_enable_o  = en_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_reset_stack_value: assert property (exc_req_o && exc_pos_o == evp_pkg::POS_RESET |->
		stack_init_o == $past(vt_r[evp_pkg::POS_STACK]))
		else $error("stack value not from slot 0");
	a_handler_from_slot: assert property (take && !exc_ack_i |=>
		exc_req_o && handler_o == $past(vt_r[win_pos]))
		else $error("handler not from matching slot");
	a_nmi_preempts_all: assert property (pend_r[evp_pkg::POS_NMI] && !pend_r[evp_pkg::POS_RESET]
		&& !act_r[evp_pkg::POS_NMI] && !exc_ack_i |=> exc_req_o && exc_pos_o == evp_pkg::POS_NMI)
		else $error("NMI not requested");
	a_fault_escalates: assert property (usage_fault_i && !fault_handler_en_i[evp_pkg::FLT_USAGE]
		|=> pend_r[evp_pkg::POS_HARD])
		else $error("disabled fault did not escalate");
	a_svc_pends: assert property (svc_i |=> pend_r[evp_pkg::POS_SVC])
		else $error("service call not pended");
	a_pendable_service_request_soft_only: assert property ($rose(pend_r[evp_pkg::POS_PENDABLE_SERVICE_REQUEST]) |-> $past(pendable_service_request_set_i))
		else $error("pendable request set without software");
	a_tick_pends: assert property (system_tick_exception_i |=> pend_r[evp_pkg::POS_TICK])
		else $error("tick not pended");
	a_reserved_quiet: assert property ((pend_r & evp_pkg::RESERVED_MASK) == '0
		&& !(exc_req_o && evp_pkg::RESERVED_MASK[exc_pos_o]))
		else $error("reserved position raised");
	a_level_line_pends: assert property (periph_irq_i[0] |=> pend_r[evp_pkg::POS_TIMER1])
		else $error("level line not pended");
	a_ack_then_gap: assert property (exc_ack_i && exc_req_o |=> !exc_req_o ##1
		(act_r[$past(exc_pos_o, 2)] || $past(exc_pos_o, 2) == evp_pkg::POS_RESET || $past(exc_return_i)))
		else $error("ack did not stack the exception");

	c_reset_taken: cover property (exc_req_o && exc_pos_o == evp_pkg::POS_RESET && exc_ack_i);
	c_nested: cover property (act_r[evp_pkg::POS_TICK] && exc_req_o && exc_pos_o == evp_pkg::POS_NMI);
	c_tail_chain: cover property (exc_return_i ##1 exc_req_o);
	c_escalation: cover property (mem_fault_i && !fault_handler_en_i[evp_pkg::FLT_MEM]);
endmodule

// ==== src/evp_pkg.sv ====
// Constants for the exception vector prioritizer.
// Assumes a single core clock domain and a 36-slot vector table.
package evp_pkg;
	localparam int NUM_POS  = 36;
	localparam int POS_W    = 6;
	localparam int LVL_W    = 6;
	localparam int PRI_W    = 5;
	localparam int VEC_W    = 32;
	localparam int IRQ_BASE = 16;
	localparam int NUM_IRQ  = 20;
	localparam int NUM_FLT  = 3;

	typedef logic [POS_W-1:0] evp_pos_t;
	typedef logic [LVL_W-1:0] evp_lvl_t;
	typedef logic [PRI_W-1:0] evp_pri_t;

	// System positions
	localparam evp_pos_t POS_STACK  = 6'h00;
	localparam evp_pos_t POS_RESET  = 6'h01;
	localparam evp_pos_t POS_NMI    = 6'h02;
	localparam evp_pos_t POS_HARD   = 6'h03;
	localparam evp_pos_t POS_MEM    = 6'h04;
	localparam evp_pos_t POS_BUS    = 6'h05;
	localparam evp_pos_t POS_USAGE  = 6'h06;
	localparam evp_pos_t POS_SVC    = 6'h0B;
	localparam evp_pos_t POS_DBGMON = 6'h0C;
	localparam evp_pos_t POS_PENDABLE_SERVICE_REQUEST = 6'h0E;
	localparam evp_pos_t POS_TICK   = 6'h0F;
	// Peripheral positions, line n sits at IRQ_BASE + n
	localparam evp_pos_t POS_TIMER1 = 6'h10;
	localparam evp_pos_t POS_TIMER2 = 6'h11;
	localparam evp_pos_t POS_MGMT   = 6'h12;
	localparam evp_pos_t POS_BBAND  = 6'h13;
	localparam evp_pos_t POS_SLEEP  = 6'h14;
	localparam evp_pos_t POS_SER1   = 6'h15;
	localparam evp_pos_t POS_SER2   = 6'h16;
	localparam evp_pos_t POS_SECUR  = 6'h17;
	localparam evp_pos_t POS_RTIMER = 6'h18;
	localparam evp_pos_t POS_RTX    = 6'h19;
	localparam evp_pos_t POS_RRX    = 6'h1A;
	localparam evp_pos_t POS_CONV   = 6'h1B;
	localparam evp_pos_t POS_PIN_A  = 6'h1C;
	localparam evp_pos_t POS_PIN_B  = 6'h1D;
	localparam evp_pos_t POS_PIN_C  = 6'h1E;
	localparam evp_pos_t POS_PIN_D  = 6'h1F;
	localparam evp_pos_t POS_DEBUG  = 6'h20;
	localparam evp_pos_t POS_SER3   = 6'h21;
	localparam evp_pos_t POS_SER4   = 6'h22;
	localparam evp_pos_t POS_BUSDEV = 6'h23;

	// Fault enable bit positions
	localparam int FLT_MEM   = 0;
	localparam int FLT_BUS   = 1;
	localparam int FLT_USAGE = 2;

	// Levels: lower is more urgent
	localparam evp_lvl_t LVL_RESET = 6'h00;
	localparam evp_lvl_t LVL_NMI   = 6'h01;
	localparam evp_lvl_t LVL_HARD  = 6'h02;
	localparam evp_lvl_t LVL_CFG   = 6'h03;
	localparam evp_lvl_t LVL_BASE  = 6'h3F;

	localparam logic [NUM_POS-1:0] RESERVED_MASK = 36'h0_0000_2780;
	localparam logic [IRQ_BASE-1:0] SYS_ALWAYS  = 16'hFFFF;
	localparam evp_pri_t PRI_RST = 5'h00;
	localparam logic [VEC_W-1:0] VEC_RST = 32'h0000_0000;

	function automatic evp_lvl_t evp_level(input evp_pos_t pos, input evp_pri_t pri);
		if (pos == POS_RESET || pos == POS_STACK)
			return LVL_RESET;
		else if (pos == POS_NMI)
			return LVL_NMI;
		else if (pos == POS_HARD)
			return LVL_HARD;
		else
			return LVL_CFG + LVL_W'(pri);
	endfunction
endpackage

// ==== src/evp_arbiter.sv ====
// Picks the most urgent requesting position.
// Assumes levels are already resolved per position; purely combinational.
`timescale 1ns/1ns
module evp_arbiter (
	// Requests and their levels
	input  wire logic [evp_pkg::NUM_POS-1:0] req_i,
	input  wire evp_pkg::evp_lvl_t           lvl_i [evp_pkg::NUM_POS],
	// Winner
	output logic                             valid_o,
	output evp_pkg::evp_pos_t                pos_o,
	output evp_pkg::evp_lvl_t                lvl_o
);
	always_comb begin
		valid_o = 1'b0;
		pos_o   = evp_pkg::POS_STACK;
		lvl_o   = evp_pkg::LVL_BASE;
		// Strict compare: on equal level the lower position keeps the win
		for (int i = 0; i < evp_pkg::NUM_POS; i++) begin
			if (req_i[i] && (!valid_o || lvl_i[i] < lvl_o)) begin
				valid_o = 1'b1;
				pos_o   = evp_pkg::POS_W'(i);
				lvl_o   = lvl_i[i];
			end
		end
	end
endmodule

// ==== verif/evp_cpu_model.sv ====
// Core model: acks shown requests, leaves each handler later.
// Assumes the prioritizer drives a registered request level.
`timescale 1ns/1ns
module evp_cpu_model #(
	parameter int HOLD = 20
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Request side
	input  wire logic       exc_req_i,
	input  wire logic       go_i,
	input  wire logic [3:0] lat_i,
	// Answers
	output logic            exc_ack_o,
	output logic            exc_return_o
);
	logic [3:0] wait_r;
	logic [5:0] hold_r;
	logic [3:0] open_r;
	logic       take;
	logic       leave;
	// Ack only a raised request, never one already acked
	always_comb take = exc_req_i && go_i && !exc_ack_o && wait_r >= lat_i;
	always_comb leave = hold_r == 6'h00 && open_r != 4'h0 && !take;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			exc_ack_o    <= 1'b0;
			exc_return_o <= 1'b0;
			wait_r       <= 4'h0;
			hold_r       <= 6'h00;
			open_r       <= 4'h0;
		end else begin
			exc_ack_o    <= take;
			exc_return_o <= leave;
			wait_r       <= (exc_req_i && go_i && !take) ? wait_r + 4'h1 : 4'h0;
			hold_r       <= (take || leave) ? 6'(HOLD) : ((hold_r != 6'h00) ? hold_r - 6'h01 : 6'h00);
			open_r       <= open_r + 4'(take) - 4'(leave);
		end
	end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the exception vector prioritizer.
// Assumes a core model that acks requests and returns later.
`timescale 1ns/1ns
module tb;
	logic              clk_i = 0;
	logic              rst_i = 1;
	logic [8:0]        ev = '0;
	logic [2:0]        fault_handler_en_i = 3'h7;
	logic              monitor_en_i = 1;
	logic              halting_i = 0;
	logic              nmi_pin_i = 0;
	logic              go = 1;
	logic [3:0]        lat = 0;
	logic [19:0]       periph_irq_i = '0;
	logic [19:0]       pending_set_register_i = '0;
	logic [19:0]       pending_clr_i = '0;
	logic [19:0]       enable_set_register_i = '0;
	logic [19:0]       enable_clr_i = '0;
	logic              prio_we_i = 0;
	logic              vt_we_i = 0;
	evp_pkg::evp_pos_t prio_pos_i = '0;
	evp_pkg::evp_pos_t vt_pos_i = '0;
	evp_pkg::evp_pri_t prio_val_i = '0;
	logic [31:0]       vt_data_i = '0;
	logic              exc_ack_i;
	logic              exc_return_i;
	logic              exc_req_o;
	evp_pkg::evp_pos_t exc_pos_o;
	logic [31:0]       handler_o;
	logic [31:0]       stack_init_o;
	evp_pkg::evp_lvl_t running_lvl_o;
	logic [35:0]       active_o;
	logic [35:0]       pending_o;
	logic [19:0]       irq_enable_o;
	logic [15:0]       rnd = 16'h42B7;
	int                n_fail = 0;
	int                n_compared = 0;
	int                ep [36];
	int                pr [36];
	logic [31:0]       vt_exp [36];
	int                tgt [8] = '{4, 5, 5, 6, 11, 12, 14, 15};

	always #2 clk_i = ~clk_i;

	evp_core i_dut (.clk_i, .rst_i, .nmi_pin_i, .mem_fault_i(ev[0]), .bus_fault_precise_i(ev[1]),
		.bus_fault_imprecise_i(ev[2]), .usage_fault_i(ev[3]), .svc_i(ev[4]), .debug_mon_i(ev[5]),
		.monitor_en_i, .halting_i, .pendable_service_request_set_i(ev[6]), .pendable_service_request_clr_i(ev[8]), .system_tick_exception_i(ev[7]),
		.fault_handler_en_i, .periph_irq_i, .pending_set_register_i, .pending_clr_i,
		.enable_set_register_i, .enable_clr_i, .prio_we_i, .prio_pos_i, .prio_val_i, .vt_we_i,
		.vt_pos_i, .vt_data_i, .exc_ack_i, .exc_return_i, .exc_req_o, .exc_pos_o, .handler_o,
		.stack_init_o, .running_lvl_o, .active_o, .pending_o, .irq_enable_o);
	evp_cpu_model i_cpu (.clk_i, .rst_i, .exc_req_i(exc_req_o), .go_i(go), .lat_i(lat),
		.exc_ack_o(exc_ack_i), .exc_return_o(exc_return_i));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Expected winner: fixed levels first, then 3 + priority, ties to lower slot
	function automatic int pick();
		int b;
		int bl;
		int l;
		b = -1;
		bl = 1000;
		for (int p = 0; p < 36; p++) begin
			l = (p == 2) ? 1 : (p == 3) ? 2 : (p < 2) ? 0 : 3 + pr[p];
			if (ep[p] != 0 && l < bl) begin
				bl = l;
				b = p;
			end
		end
		return b;
	endfunction
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic strobe(input int b);
		@(posedge clk_i);
		ev[b] <= 1'b1;
		@(posedge clk_i);
		ev[b] <= 1'b0;
	endtask
	// Compare at the cycle the core model acks
	task automatic take_one();
		int p;
		p = pick();
		for (int i = 0; i < 200; i++) begin
			@(negedge clk_i);
			if (exc_req_o === 1'b1 && exc_ack_i === 1'b1) begin
				chk(exc_pos_o, 36'(p));
				chk(handler_o, vt_exp[p]);
				chk(pending_o & evp_pkg::RESERVED_MASK, '0);
				ep[p] = 0;
				return;
			end
		end
		n_fail++;
		close_out();
	endtask

	initial begin
		for (int p = 0; p < 36; p++) begin
			ep[p] = 0;
			pr[p] = 0;
			vt_exp[p] = '0;
		end
		cyc(5);
		@(negedge clk_i);
		chk(pending_o, 36'h0_0000_0002);
		chk(running_lvl_o, 36'h3F);
		@(posedge clk_i);
		rst_i <= 1'b0;
		ep[1] = 1;
		take_one();
		chk(stack_init_o, '0);
		cyc(2);
		@(negedge clk_i);
		chk(active_o, '0);
		chk(running_lvl_o, 36'(evp_pkg::LVL_BASE));
		for (int p = 0; p < 36; p++) begin
			rnd = lfsr(rnd);
			@(posedge clk_i);
			vt_we_i <= 1'b1;
			vt_pos_i <= 6'(p);
			vt_data_i <= {rnd, 16'(p)};
			vt_exp[p] = {rnd, 16'(p)};
		end
		@(posedge clk_i);
		vt_we_i <= 1'b0;
		cyc(30);
		for (int i = 0; i < 8; i++) begin
			lat <= 4'(i);
			strobe(i);
			ep[tgt[i]] = 1;
			take_one();
			cyc(30);
		end
		// Memory and usage handlers off: both must land on hard fault
		fault_handler_en_i <= 3'b010;
		for (int k = 0; k < 4; k += 3) begin
			strobe(k);
			ep[3] = 1;
			take_one();
			cyc(30);
		end
		fault_handler_en_i <= 3'b111;
		monitor_en_i <= 1'b0;
		strobe(5);
		monitor_en_i <= 1'b1;
		halting_i <= 1'b1;
		strobe(5);
		go <= 1'b0;
		strobe(6);
		strobe(8);
		cyc(2);
		@(negedge clk_i);
		chk(pending_o[12], 1'b0);
		chk(pending_o[14], 1'b0);
		chk(exc_req_o, 1'b0);
		@(posedge clk_i);
		halting_i <= 1'b0;
		// Round 0 forces equal priorities
		for (int r = 0; r < 3; r++) begin
			int a;
			int b;
			rnd = lfsr(rnd);
			a = rnd % 20;
			b = (a + 1 + rnd[9:5] % 19) % 20;
			pr[16 + a] = rnd[4:0];
			pr[16 + b] = (r == 0) ? pr[16 + a] : rnd[14:10];
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_i);
				prio_we_i <= 1'b1;
				prio_pos_i <= 6'(16 + (k == 0 ? a : b));
				prio_val_i <= 5'(pr[16 + (k == 0 ? a : b)]);
			end
			@(posedge clk_i);
			prio_we_i <= 1'b0;
			go <= 1'b0;
			pending_set_register_i <= (20'h1 << a) | (20'h1 << b);
			@(posedge clk_i);
			pending_set_register_i <= '0;
			ep[16 + a] = 1;
			ep[16 + b] = 1;
			cyc(3);
			@(negedge clk_i);
			chk(exc_req_o, 1'b0);
			chk(pending_o[16 + b], 1'b1);
			@(posedge clk_i);
			enable_set_register_i <= (20'h1 << a) | (20'h1 << b);
			go <= 1'b1;
			@(posedge clk_i);
			enable_set_register_i <= '0;
			take_one();
			take_one();
			@(posedge clk_i);
			enable_clr_i <= (20'h1 << a) | (20'h1 << b);
			@(posedge clk_i);
			enable_clr_i <= '0;
			cyc(30);
			chk(irq_enable_o, '0);
		end
		// Same-cycle set and clear: set wins, then clear alone empties
		pending_set_register_i <= 20'h0_0001;
		pending_clr_i <= 20'h0_0001;
		@(posedge clk_i);
		pending_set_register_i <= '0;
		@(negedge clk_i);
		chk(pending_o[16], 1'b1);
		@(posedge clk_i);
		pending_clr_i <= '0;
		@(negedge clk_i);
		chk(pending_o[16], 1'b0);
		@(posedge clk_i);
		enable_set_register_i <= 20'hF_FFFF;
		@(posedge clk_i);
		enable_set_register_i <= '0;
		for (int n = 0; n < 20; n++) begin
			lat <= 4'(n % 3);
			periph_irq_i[n] <= 1'b1;
			@(posedge clk_i);
			periph_irq_i[n] <= 1'b0;
			ep[16 + n] = 1;
			take_one();
			cyc(30);
		end
		periph_irq_i[0] <= 1'b1;
		@(posedge clk_i);
		periph_irq_i[0] <= 1'b0;
		ep[16] = 1;
		take_one();
		@(posedge clk_i);
		nmi_pin_i <= 1'b1;
		ep[2] = 1;
		take_one();
		@(negedge clk_i);
		chk(active_o[16], 1'b1);
		// Running level is registered one cycle after the active set
		@(negedge clk_i);
		chk(running_lvl_o, 36'(evp_pkg::LVL_NMI));
		@(posedge clk_i);
		nmi_pin_i <= 1'b0;
		cyc(60);
		rst_i <= 1'b1;
		go <= 1'b0;
		for (int p = 0; p < 36; p++)
			vt_exp[p] = '0;
		cyc(2);
		rst_i <= 1'b0;
		ep[1] = 1;
		// Reload stack and reset slots while the reset request waits
		for (int p = 0; p < 2; p++) begin
			rnd = lfsr(rnd);
			@(posedge clk_i);
			vt_we_i <= 1'b1;
			vt_pos_i <= 6'(p);
			vt_data_i <= {16'(p), rnd};
			vt_exp[p] = {16'(p), rnd};
		end
		@(posedge clk_i);
		vt_we_i <= 1'b0;
		go <= 1'b1;
		take_one();
		chk(stack_init_o, vt_exp[0]);
		close_out();
	end
endmodule
